/* File: hw/exec_map.svh */
// widths, field positions, opcodes and reset values of the immediate and port group
`ifndef EXEC_MAP_SVH
`define EXEC_MAP_SVH

`define INSTR_W 10
`define NIB_W 4
`define BANK_W 2
`define PC_W_DEFAULT 11

// opcode patterns; the three loads are compared after masking with the matching field mask, the rest whole
`define OP_NO_OPERATION 10'h000
`define OP_LOAD_ACC 10'h070
`define MASK_LOAD_ACC 10'h3f0
`define OP_LOAD_COL_ROW 10'h300
`define MASK_LOAD_COL_ROW 10'h300
`define OP_LOAD_BANK 10'h048
`define MASK_LOAD_BANK 10'h3fc
`define OP_OUT_BIT 10'h21f
`define OP_OUT_PORT0 10'h220
`define OP_OUT_PORT1 10'h223

// immediate field positions
`define COL_HI 7
`define COL_LO 4
`define ROW_HI 3
`define ROW_LO 0
`define BANK_HI 1
`define BANK_LO 0

// reset values
`define ACC_RST 4'h0
`define PTR_RST 4'h0
`define BANK_RST 2'h0
`define PORT_RST 4'h0
`define BIT_PORT_RST 1'h0
`define CARRY_RST 1'h0

`endif

/* File: hw/exec_pkg.sv */
// types shared by the decoder and the execution unit
package exec_pkg;
  typedef enum {
    OPC_NONE,
    OPC_NO_OPERATION,
    OPC_LOAD_ACC,
    OPC_LOAD_COL_ROW,
    OPC_LOAD_BANK,
    OPC_OUT_BIT,
    OPC_OUT_PORT0,
    OPC_OUT_PORT1
  } opclass_e;
endpackage : exec_pkg

/* File: hw/decode_if.sv */
// decoded instruction carried from the decoder to the execution unit
`timescale 1ns/1ps
interface decode_if;
  import exec_pkg::*;
  logic [9:0] word;
  opclass_e op;
  modport dec (input word, output op);
  modport exe (output word, input op);
endinterface : decode_if

/* File: hw/instr_decoder.sv */
// combinational decoder of the immediate and port output instruction group
`timescale 1ns/1ps
`include "exec_map.svh"
module instr_decoder (
  decode_if.dec dec
);
  import exec_pkg::*;

  function automatic logic match(input logic [9:0] w, input logic [9:0] m,
                                 input logic [9:0] p);
    match = ((w & m) == p);
  endfunction : match

  always_comb begin
    // top two bits pick col/row load
    if (match(dec.word, `MASK_LOAD_COL_ROW, `OP_LOAD_COL_ROW)) begin
      dec.op = OPC_LOAD_COL_ROW;
    end else if (match(dec.word, `MASK_LOAD_ACC, `OP_LOAD_ACC)) begin
      dec.op = OPC_LOAD_ACC;
    end else if (match(dec.word, `MASK_LOAD_BANK, `OP_LOAD_BANK)) begin
      dec.op = OPC_LOAD_BANK;
    end else if (dec.word == `OP_NO_OPERATION) begin
      dec.op = OPC_NO_OPERATION;
    end else if (dec.word == `OP_OUT_BIT) begin
      dec.op = OPC_OUT_BIT;
    end else if (dec.word == `OP_OUT_PORT0) begin
      dec.op = OPC_OUT_PORT0;
    end else if (dec.word == `OP_OUT_PORT1) begin
      dec.op = OPC_OUT_PORT1;
    end else begin
      dec.op = OPC_NONE;
    end
  end
endmodule : instr_decoder

/* File: hw/load_immediate_and_port_output_exec.sv */
// execution unit for immediate loads, no-operation and accumulator port writes
//
// Operation
// - load_acc_immediate puts a 4-bit value in the accumulator, only the first of a run acts.
// - load_col_row_pointers puts the first nibble in the column and the second in the row.
// - back to back load_col_row_pointers words after the first are skipped as no-ops.
// - load_col_row_pointers is the word with both top bits set, column 7:4 and row 3:0.
// - load_bank_pointer writes the two low instruction bits into the bank pointer.
// - no_operation only advances the program counter by one.
// - out_bit_port_from_acc drives the one-bit port with accumulator bit 0.
// - out_port0_from_acc copies the accumulator to output_port_0.
// - out_port1_from_acc copies the accumulator to output_port_1.
`timescale 1ns/1ps
`include "exec_map.svh"
module load_immediate_and_port_output_exec #(
  parameter int PC_W = `PC_W_DEFAULT
) (
  input wire logic clock_i,
  input wire logic reset_i,
  input wire logic instr_valid_i,
  input wire logic [9:0] instr_i,
  output logic [PC_W-1:0] pc_o,
  output logic [3:0] acc_o,
  output logic carry_flag_o,
  output logic [3:0] col_ptr_o,
  output logic [3:0] row_ptr_o,
  output logic [1:0] bank_ptr_o,
  output logic bit_port_o,
  output logic [3:0] output_port_0_o,
  output logic [3:0] output_port_1_o,
  output logic skip_o,
  output logic unknown_o
);
  import exec_pkg::*;

  // refused at elaboration: the counter must fit the fetch address range
  if (PC_W < 1 || PC_W > 16) begin : g_pc_w_check
    $error("PC_W out of range");
  end

  ////////////////////////////////////////////////////////////////////////////
  // decode

  decode_if dif ();
  opclass_e op;
  assign dif.word = instr_i;
  assign op = dif.op;

  instr_decoder u_dec (
    .dec(dif.dec)
  );

  ////////////////////////////////////////////////////////////////////////////
  // state

  logic [PC_W-1:0] pc, next_pc;
  logic [3:0] acc, next_acc;
  logic carry, next_carry;
  logic [3:0] col, next_col;
  logic [3:0] row, next_row;
  logic [1:0] bank, next_bank;
  logic kbit, next_kbit;
  logic [3:0] port0, next_port0;
  logic [3:0] port1, next_port1;
  // class of the previous word, seen or skipped, for run detection
  opclass_e last_op, next_last_op;
  logic skip, next_skip;
  logic unknown, next_unknown;
  logic run_skip;

  // a run continues even over skipped members, so last_op follows every word
  assign run_skip = (op == OPC_LOAD_ACC || op == OPC_LOAD_COL_ROW) && (last_op == op);

  always_comb begin
    next_pc = pc;
    next_acc = acc;
    next_carry = carry;
    next_col = col;
    next_row = row;
    next_bank = bank;
    next_kbit = kbit;
    next_port0 = port0;
    next_port1 = port1;
    next_last_op = last_op;
    next_skip = 1'b0;
    next_unknown = 1'b0;
    if (instr_valid_i) begin
      // one word, one cycle, carry untouched
      next_pc = pc + PC_W'(1);
      next_last_op = op;
      next_skip = run_skip;
      // first of a run loads acc
      // later loads of a run do nothing
      if (!run_skip) begin
        case (op)
          OPC_LOAD_ACC: begin
            next_acc = instr_i[`NIB_W-1:0];
          end
          OPC_LOAD_COL_ROW: begin
            next_col = instr_i[`COL_HI:`COL_LO];
            next_row = instr_i[`ROW_HI:`ROW_LO];
          end
          OPC_LOAD_BANK: begin
            next_bank = instr_i[`BANK_HI:`BANK_LO];
          end
          OPC_NO_OPERATION: begin
            next_pc = pc + PC_W'(1);
          end
          // bit port from acc bit 0
          OPC_OUT_BIT: begin
            next_kbit = acc[0];
          end
          OPC_OUT_PORT0: begin
            next_port0 = acc;
          end
          OPC_OUT_PORT1: begin
            next_port1 = acc;
          end
          // words outside the group are flagged and otherwise ignored here
          default: begin
            next_unknown = 1'b1;
          end
        endcase
      end
    end
  end

  // ports only load on their own write
  always_ff @(posedge clock_i or posedge reset_i) begin
    if (reset_i) begin
      pc <= '0;
      acc <= `ACC_RST;
      carry <= `CARRY_RST;
      col <= `PTR_RST;
      row <= `PTR_RST;
      bank <= `BANK_RST;
      kbit <= `BIT_PORT_RST;
      port0 <= `PORT_RST;
      port1 <= `PORT_RST;
      last_op <= OPC_NONE;
      skip <= 1'b0;
      unknown <= 1'b0;
    end else begin
      pc <= next_pc;
      acc <= next_acc;
      carry <= next_carry;
      col <= next_col;
      row <= next_row;
      bank <= next_bank;
      kbit <= next_kbit;
      port0 <= next_port0;
      port1 <= next_port1;
      last_op <= next_last_op;
      skip <= next_skip;
      unknown <= next_unknown;
    end
  end

  assign pc_o = pc;
  assign acc_o = acc;
  assign carry_flag_o = carry;
  assign col_ptr_o = col;
  assign row_ptr_o = row;
  assign bank_ptr_o = bank;
  assign bit_port_o = kbit;
  assign output_port_0_o = port0;
  assign output_port_1_o = port1;
  assign skip_o = skip;
  assign unknown_o = unknown;

  ////////////////////////////////////////////////////////////////////////////
  // checks

  chk_acc_first_load: assert property (@(posedge clock_i) disable iff (reset_i)
    (instr_valid_i && op == OPC_LOAD_ACC && last_op != OPC_LOAD_ACC)
    |=> acc == $past(instr_i[3:0]))
    else $error("first acc load not taken");

  chk_acc_run_hold: assert property (@(posedge clock_i) disable iff (reset_i)
    (instr_valid_i && op == OPC_LOAD_ACC && last_op == OPC_LOAD_ACC) |=> $stable(acc) && skip)
    else $error("repeated acc load changed acc");

  chk_ptr_load: assert property (@(posedge clock_i) disable iff (reset_i)
    (instr_valid_i && op == OPC_LOAD_COL_ROW && last_op != OPC_LOAD_COL_ROW)
    |=> col == $past(instr_i[7:4]) && row == $past(instr_i[3:0]))
    else $error("col/row load wrong");

  chk_ptr_run_hold: assert property (@(posedge clock_i) disable iff (reset_i)
    (instr_valid_i && op == OPC_LOAD_COL_ROW && last_op == OPC_LOAD_COL_ROW)
    |=> $stable(col) && $stable(row) && skip)
    else $error("repeated col/row load acted");

  chk_ptr_decode: assert property (@(posedge clock_i) disable iff (reset_i)
    instr_i[9:8] == 2'h3 |-> op == OPC_LOAD_COL_ROW)
    else $error("col/row load not decoded");

  chk_bank_load: assert property (@(posedge clock_i) disable iff (reset_i)
    (instr_valid_i && op == OPC_LOAD_BANK) |=> bank == $past(instr_i[1:0]))
    else $error("bank load wrong");

  chk_pc_only_step: assert property (@(posedge clock_i) disable iff (reset_i)
    (instr_valid_i && op == OPC_NO_OPERATION)
    |=> pc == $past(pc) + PC_W'(1) && $stable(acc) && $stable(col) && $stable(row)
    && $stable(bank) && $stable(kbit) && $stable(port0) && $stable(port1))
    else $error("no_operation changed state");

  chk_bit_port: assert property (@(posedge clock_i) disable iff (reset_i)
    (instr_valid_i && op == OPC_OUT_BIT) |=> kbit == $past(acc[0]) && $stable(acc))
    else $error("bit port wrong");

  chk_port0_write: assert property (@(posedge clock_i) disable iff (reset_i)
    (instr_valid_i && op == OPC_OUT_PORT0) |=> port0 == $past(acc) && $stable(carry))
    else $error("port 0 write wrong");

  chk_port1_write: assert property (@(posedge clock_i) disable iff (reset_i)
    (instr_valid_i && op == OPC_OUT_PORT1) |=> port1 == $past(acc) && $stable(carry))
    else $error("port 1 write wrong");

  chk_carry_fixed: assert property (@(posedge clock_i) disable iff (reset_i)
    instr_valid_i |=> $stable(carry) && pc == $past(pc) + PC_W'(1))
    else $error("carry moved or cycle count wrong");

  chk_port0_hold: assert property (@(posedge clock_i) disable iff (reset_i)
    !(instr_valid_i && op == OPC_OUT_PORT0) |=> $stable(port0))
    else $error("port 0 changed without write");

  chk_port1_hold: assert property (@(posedge clock_i) disable iff (reset_i)
    !(instr_valid_i && op == OPC_OUT_PORT1) |=> $stable(port1))
    else $error("port 1 changed without write");
endmodule : load_immediate_and_port_output_exec

/* File: sim/prog_mem_model.sv */
// program memory model feeding instruction words to the execution unit
`timescale 1ns/1ps
module prog_mem_model (
  input wire logic clock_i,
  input wire logic [10:0] pc_i,
  input wire logic fetch_en_i,
  output logic instr_valid_o,
  output logic [9:0] instr_o
);
  logic [9:0] rom [0:2047];
  initial begin
    instr_valid_o = 1'b0;
    instr_o = 10'h155;
  end
  // words change at the falling edge, away from the sampling edge;
  // a released bus inverts its word on each falling edge, so every second idle cycle shows the last word again
  always @(negedge clock_i) begin
    instr_valid_o <= fetch_en_i;
    instr_o <= fetch_en_i ? rom[pc_i] : ~instr_o;
  end
endmodule : prog_mem_model

/* File: sim/load_immediate_and_port_output_exec_test.sv */
// self-checking testbench of the immediate load and port output unit
`timescale 1ns/1ps
module load_immediate_and_port_output_exec_test;
  logic clock_i, reset_i, fetch_en, instr_valid;
  logic [9:0] instr;
  logic [10:0] pc_o, exp_pc;
  logic [3:0] acc_o, col_ptr_o, row_ptr_o, output_port_0_o, output_port_1_o;
  logic [1:0] bank_ptr_o;
  logic carry_flag_o, bit_port_o, skip_o, unknown_o;
  int n_fail = 0;
  int checks_done = 0;

  load_immediate_and_port_output_exec dut (.clock_i(clock_i), .reset_i(reset_i),
    .instr_valid_i(instr_valid), .instr_i(instr), .pc_o(pc_o), .acc_o(acc_o),
    .carry_flag_o(carry_flag_o), .col_ptr_o(col_ptr_o), .row_ptr_o(row_ptr_o),
    .bank_ptr_o(bank_ptr_o), .bit_port_o(bit_port_o), .output_port_0_o(output_port_0_o),
    .output_port_1_o(output_port_1_o), .skip_o(skip_o), .unknown_o(unknown_o));
  prog_mem_model mem (.clock_i(clock_i), .pc_i(pc_o), .fetch_en_i(fetch_en),
    .instr_valid_o(instr_valid), .instr_o(instr));

  initial begin
    clock_i = 1'b0;
    forever #2 clock_i = ~clock_i;
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic end_of_test();
    $display("checks_done=%0d n_fail=%0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : end_of_test

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_fail++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  // one word per cycle, checked 1 ns after the rising edge that takes it
  task automatic step(input logic [9:0] w, input logic sk, input logic unk);
    mem.rom[exp_pc] = w;
    fetch_en = 1'b1;
    @(posedge clock_i);
    #1;
    exp_pc = exp_pc + 11'h1;
    chk(16'(pc_o), 16'(exp_pc));
    chk(16'(carry_flag_o), 16'h0);
    chk(16'(skip_o), 16'(sk));
    chk(16'(unknown_o), 16'(unk));
  endtask : step

  task automatic idle();
    fetch_en = 1'b0;
    @(posedge clock_i);
    #1;
  endtask : idle

  ////////////////////////////////////////////////////////////////////////////
  task automatic t_reset();
    chk(16'(pc_o), 16'h0);
    chk(16'(acc_o), 16'h0);
    chk({8'h0, col_ptr_o, row_ptr_o}, 16'h0);
    chk({output_port_1_o, output_port_0_o, 3'h0, bit_port_o}, 16'h0);
  endtask : t_reset

  task automatic t_acc();
    step(10'h075, 1'b0, 1'b0);
    chk(16'(acc_o), 16'h5);
    step(10'h079, 1'b1, 1'b0);
    chk(16'(acc_o), 16'h5);
    // an idle cycle must not end the run
    idle();
    step(10'h07a, 1'b1, 1'b0);
    chk(16'(acc_o), 16'h5);
    step(10'h000, 1'b0, 1'b0);
    chk(16'(acc_o), 16'h5);
    step(10'h07f, 1'b0, 1'b0);
    chk(16'(acc_o), 16'hf);
    idle();
  endtask : t_acc

  task automatic t_ptr();
    step(10'h3ab, 1'b0, 1'b0);
    chk({8'h0, col_ptr_o, row_ptr_o}, 16'h00ab);
    step(10'h3cd, 1'b1, 1'b0);
    chk({8'h0, col_ptr_o, row_ptr_o}, 16'h00ab);
    step(10'h000, 1'b0, 1'b0);
    chk({8'h0, col_ptr_o, row_ptr_o}, 16'h00ab);
    step(10'h3f0, 1'b0, 1'b0);
    chk({8'h0, col_ptr_o, row_ptr_o}, 16'h00f0);
    // with one top bit clear, 2f1 is no col/row load and falls outside the group
    step(10'h2f1, 1'b0, 1'b1);
    chk({8'h0, col_ptr_o, row_ptr_o}, 16'h00f0);
    idle();
  endtask : t_ptr

  task automatic t_bank();
    for (int z = 3; z >= 0; z--) begin
      step(10'h048 | 10'(z), 1'b0, 1'b0);
      chk(16'(bank_ptr_o), 16'(z));
    end
    idle();
  endtask : t_bank

  task automatic t_ports();
    step(10'h07a, 1'b0, 1'b0);
    step(10'h220, 1'b0, 1'b0);
    chk(16'(output_port_0_o), 16'ha);
    step(10'h21f, 1'b0, 1'b0);
    chk(16'(bit_port_o), 16'h0);
    step(10'h075, 1'b0, 1'b0);
    step(10'h223, 1'b0, 1'b0);
    chk(16'(output_port_1_o), 16'h5);
    chk(16'(output_port_0_o), 16'ha);
    step(10'h21f, 1'b0, 1'b0);
    chk(16'(bit_port_o), 16'h1);
    chk(16'(acc_o), 16'h5);
    idle();
    chk({output_port_1_o, output_port_0_o, 3'h0, bit_port_o}, 16'h05a1);
  endtask : t_ports

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    reset_i = 1'b1;
    fetch_en = 1'b0;
    exp_pc = 11'h0;
    repeat (5) @(negedge clock_i);
    reset_i = 1'b0;
    @(posedge clock_i);
    #1;
    t_reset();
    t_acc();
    t_ptr();
    t_bank();
    t_ports();
    end_of_test();
  end

  // the program is well under a hundred cycles; five thousand means a hang
  initial begin
    #20000;
    n_fail++;
    end_of_test();
  end
endmodule : load_immediate_and_port_output_exec_test
